// *** verilog/sss_pkg.sv ***
// Constants and types for the status link ends.
// Assumes a 25 MHz clock; cycle counts derive from it.
package sss_pkg;

  // ==========================================================
  // Clock
  localparam int CLK_KHZ = 25000;

  // ==========================================================
  // Status character timing
  localparam int BIT_MS = 150;
  localparam int BIT_CYC = BIT_MS * CLK_KHZ;
  localparam int GAP_MS = 5000;
  localparam int GAP_CYC = GAP_MS * CLK_KHZ;
  localparam int CHAR_BITS = 2;

  // ==========================================================
  // Safety output test pulses
  localparam int PULSE_US = 100;
  localparam int PULSE_CYC = PULSE_US * CLK_KHZ / 1000;
  localparam int SHIFT_MS = 500;
  localparam int SHIFT_CYC = SHIFT_MS * CLK_KHZ;
  localparam int PERIOD_MS = 1000;
  localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;

  // ==========================================================
  // Restart window and pulse
  localparam int RST_MIN_MS = 30;
  localparam int RST_MIN_CYC = RST_MIN_MS * CLK_KHZ;
  localparam int RST_MAX_MS = 5000;
  localparam int RST_MAX_CYC = RST_MAX_MS * CLK_KHZ;
  localparam int RST_PULSE_MS = 100;
  localparam int RST_PULSE_CYC = RST_PULSE_MS * CLK_KHZ;

  // ==========================================================
  // Indicator
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int BOOT_BLINK_BASE = 2;
  localparam int PAUSE_PHASES = 4;
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_RED = 2'h1;
  localparam logic [1:0] LED_GREEN = 2'h2;
  localparam logic [1:0] LED_YELLOW = 2'h3;

  // ==========================================================
  // Controller registers
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {SSS_AUTO_FB, SSS_AUTO, SSS_MANUAL, SSS_FIRST, SSS_MEMBER} sss_mode_e;
  typedef enum logic [1:0] {TX_GAP, TX_START, TX_CELL} sss_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_WAIT} sss_rx_e;

endpackage

// *** verilog/sss_link_if.sv ***
// Wires between sensor and controller ends.
// Assumes one shared clock; one-way levels.
`timescale 1ns/1ps
interface sss_link_if;
  logic status_line;
  logic safety_output_a;
  logic safety_output_b;
  logic chain_input_a;
  logic chain_input_b;
  logic contactor_feedback_input;

  modport dev
  (
    output status_line,
    output safety_output_a,
    output safety_output_b,
    input chain_input_a,
    input chain_input_b,
    input contactor_feedback_input
  );

  modport ctl
  (
    input status_line,
    input safety_output_a,
    input safety_output_b,
    output chain_input_a,
    output chain_input_b,
    output contactor_feedback_input
  );
endinterface

// *** verilog/sss_device.sv ***
// Sensor end: pulsed safety outputs, status line, indicator.
// Assumes synchronous, clean inputs.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Status line is square wave of chain.
// - Character opens with 150 ms low start.
// - Zero bit rises at 150 ms cell centre.
// - One bit falls at 150 ms cell centre.
// - Idle high, gap at least 5000 ms.
// - Report clear or guard-open per sensor.
// - Serial variant sends state, simple follows outputs.
// - Upstream safety outputs drive chain inputs.
// - Sample contactor feedback input for contacts.
// - Test pulses 100 us, never over 120.
// - Second output pulses offset by 500 ms.
// - Test pulses repeat every second.
// - Guard state drives outputs and status.
// - Indicator colours show each sensor state.
// - Power-up yellow blinks encode the mode.
// - Fault blinks red; standalone modes also pulse code.
// - Teach wiring enables new actuator identity.
// - Status line never gates safety outputs.
// - Chain at most sixteen, automatic only.
// - Restart valid if high 30 ms..5 s.
module sss_device
#(
  parameter int BIT_CYC = sss_pkg::BIT_CYC,
  parameter int GAP_CYC = sss_pkg::GAP_CYC,
  parameter int SHIFT_CYC = sss_pkg::SHIFT_CYC,
  parameter int PERIOD_CYC = sss_pkg::PERIOD_CYC,
  parameter int RST_MIN_CYC = sss_pkg::RST_MIN_CYC,
  parameter int RST_MAX_CYC = sss_pkg::RST_MAX_CYC,
  parameter int BLINK_CYC = sss_pkg::BLINK_CYC
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link to the far end
  sss_link_if.dev link,
  // Sensing and configuration
  input wire logic guard_closed_i,
  input wire logic programming_i,
  input wire logic serial_variant_i,
  input wire sss_pkg::sss_mode_e mode_i,
  input wire logic [3:0] fault_code_i,
  // Indications
  output logic [1:0] led_o,
  output logic outputs_on_o,
  output logic teach_enable_o
);
  import sss_pkg::*;

  // ==========================================================
  // Declarations
  logic [3:0] fault_q;
  logic standalone;
  logic in_chain;
  logic chain_ok;
  logic gate_ok;
  logic fb_prev;
  logic [31:0] rst_cnt;
  logic restart_ok;
  logic restart_armed;
  logic [31:0] pcnt;
  logic pulse_a;
  logic pulse_b;
  sss_tx_e tx_state;
  logic [31:0] tcnt;
  logic [3:0] nleft;
  logic [CHAR_BITS-1:0] word;
  logic tx_fault;
  logic tx_bit;
  logic gap_level;
  logic [31:0] bcnt;
  logic tick;
  logic phase;
  logic [4:0] seq;
  logic [4:0] blink_n;
  logic seq_on;
  logic boot_done;

  function automatic logic [4:0] boot_blinks(input sss_mode_e m);
    boot_blinks = 5'(int'(m) + BOOT_BLINK_BASE);
  endfunction

  // ==========================================================
  // Enable conditions
  assign standalone = (mode_i == SSS_AUTO_FB) || (mode_i == SSS_AUTO) || (mode_i == SSS_MANUAL);
  assign in_chain = !standalone;
  assign chain_ok = in_chain ? (link.chain_input_a && link.chain_input_b) : 1'b1;
  assign gate_ok = (mode_i == SSS_MANUAL) ? restart_armed :
                   (mode_i == SSS_AUTO_FB) ? (outputs_on_o || link.contactor_feedback_input) : 1'b1;

  // Fault latches until reset
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      fault_q <= 4'h0;
    else if (fault_q == 4'h0)
      fault_q <= fault_code_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      outputs_on_o <= 1'b0;
    else
      outputs_on_o <= guard_closed_i && chain_ok && gate_ok && (fault_q == 4'h0) && boot_done && !programming_i;
  end

  // ==========================================================
  // Restart pulse qualification
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      fb_prev <= 1'b0;
      rst_cnt <= 32'h0;
      restart_ok <= 1'b0;
    end
    else
    begin
      fb_prev <= link.contactor_feedback_input;
      if (link.contactor_feedback_input && !fb_prev)
        rst_cnt <= 32'h0;
      else if (link.contactor_feedback_input && rst_cnt < 32'(RST_MAX_CYC))
        rst_cnt <= rst_cnt + 32'h1;
      restart_ok <= !link.contactor_feedback_input && fb_prev &&
                    rst_cnt >= 32'(RST_MIN_CYC - 1) && rst_cnt <= 32'(RST_MAX_CYC - 1);
    end
  end

  // Arm drops when guard opens
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      restart_armed <= 1'b0;
    else if (!guard_closed_i)
      restart_armed <= 1'b0;
    else if (restart_ok)
      restart_armed <= 1'b1;
  end

  // ==========================================================
  // Safety output test pulses
  // one second repeat
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      pcnt <= 32'h0;
    else if (pcnt >= 32'(PERIOD_CYC - 1))
      pcnt <= 32'h0;
    else
      pcnt <= pcnt + 32'h1;
  end

  assign pulse_a = pcnt < 32'(PULSE_CYC);
  assign pulse_b = (pcnt >= 32'(SHIFT_CYC)) && (pcnt < 32'(SHIFT_CYC + PULSE_CYC));

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      link.safety_output_a <= 1'b0;
      link.safety_output_b <= 1'b0;
    end
    else
    begin
      link.safety_output_a <= outputs_on_o && !pulse_a;
      link.safety_output_b <= outputs_on_o && !pulse_b;
    end
  end

  // ==========================================================
  // Status transmitter
  // Fault pulses on low idle, character on high
  assign gap_level = (fault_q != 4'h0 && standalone) ? 1'b0 : (serial_variant_i ? 1'b1 : outputs_on_o);
  assign tx_bit = tx_fault || word[0];

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      tx_state <= TX_GAP;
      tcnt <= 32'h0;
      nleft <= 4'h0;
      word <= '0;
      tx_fault <= 1'b0;
      link.status_line <= 1'b1;
    end
    else
    begin
      case (tx_state)
        TX_GAP:
        begin
          // idle level held for the whole gap
          link.status_line <= gap_level;
          if (tcnt >= 32'(GAP_CYC - 1))
          begin
            tcnt <= 32'h0;
            if (fault_q != 4'h0 && standalone)
            begin
              tx_fault <= 1'b1;
              nleft <= fault_q;
              tx_state <= TX_CELL;
            end
            else if (serial_variant_i)
            begin
              tx_fault <= 1'b0;
              nleft <= 4'(CHAR_BITS);
              word <= {link.chain_input_a && link.chain_input_b, guard_closed_i};
              tx_state <= TX_START;
            end
          end
          else
            tcnt <= tcnt + 32'h1;
        end
        TX_START:
        begin
          link.status_line <= 1'b0;
          if (tcnt >= 32'(BIT_CYC - 1))
          begin
            tcnt <= 32'h0;
            tx_state <= TX_CELL;
          end
          else
            tcnt <= tcnt + 32'h1;
        end
        TX_CELL:
        begin
          link.status_line <= (tcnt < 32'(BIT_CYC / 2)) ? tx_bit : !tx_bit;
          if (tcnt >= 32'(BIT_CYC - 1))
          begin
            tcnt <= 32'h0;
            word <= word >> 1;
            nleft <= nleft - 4'h1;
            if (nleft == 4'h1)
              tx_state <= TX_GAP;
          end
          else
            tcnt <= tcnt + 32'h1;
        end
        default:
          tx_state <= TX_GAP;
      endcase
    end
  end

  // ==========================================================
  // Indicator
  assign tick = bcnt >= 32'(BLINK_CYC - 1);
  assign blink_n = (fault_q != 4'h0) ? {1'b0, fault_q} : boot_blinks(mode_i);
  assign seq_on = (seq < {blink_n[3:0], 1'b0}) && !seq[0];

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      bcnt <= 32'h0;
      phase <= 1'b0;
    end
    else if (tick)
    begin
      bcnt <= 32'h0;
      phase <= !phase;
    end
    else
      bcnt <= bcnt + 32'h1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      seq <= 5'h0;
      boot_done <= 1'b0;
    end
    else if (tick)
    begin
      if (seq >= 5'({blink_n[3:0], 1'b0} + 5'(PAUSE_PHASES) - 5'h1))
      begin
        seq <= 5'h0;
        if (fault_q == 4'h0)
          boot_done <= 1'b1;
      end
      else
        seq <= seq + 5'h1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      led_o <= LED_OFF;
    // red blinks for the fault code
    else if (fault_q != 4'h0)
      led_o <= seq_on ? LED_RED : LED_OFF;
    else if (!boot_done)
      led_o <= seq_on ? LED_YELLOW : LED_OFF;
    else if (programming_i)
      led_o <= phase ? LED_GREEN : LED_OFF;
    else if (outputs_on_o)
      led_o <= LED_GREEN;
    else if (in_chain && guard_closed_i && !chain_ok)
      led_o <= phase ? LED_GREEN : LED_RED;
    else if (mode_i == SSS_MANUAL && guard_closed_i)
      led_o <= LED_YELLOW;
    else
      led_o <= LED_RED;
  end

  // ==========================================================
  // Teach wiring detect
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      teach_enable_o <= 1'b0;
    else
      teach_enable_o <= (link.chain_input_a == link.safety_output_a) &&
                        (link.chain_input_b == link.status_line) && link.contactor_feedback_input;
  end

endmodule

// *** verilog/sss_ctrl.sv ***
// Controller end: drives chain inputs, decodes status.
// Assumes one AXI4-Lite write and read at a time.
`timescale 1ns/1ps
module sss_ctrl
#(
  parameter int BIT_CYC = sss_pkg::BIT_CYC,
  parameter int RST_PULSE_CYC = sss_pkg::RST_PULSE_CYC
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link to the sensor
  sss_link_if.ctl link,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  import sss_pkg::*;

  // ==========================================================
  // Declarations
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic ctrl_wr;
  logic stat_rd;
  logic [2:0] ctrl;
  logic [31:0] pulse_cnt;
  logic pulse_busy;
  sss_rx_e rx_state;
  logic [31:0] rcnt;
  logic [3:0] rleft;
  logic [CHAR_BITS-1:0] rshift;
  logic [CHAR_BITS-1:0] rx_word;
  logic rx_valid;
  logic line_prev;

  assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign ctrl_wr = wr_fire && aw_addr == REG_CTRL && w_strb[0];
  assign stat_rd = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == REG_STAT;

  // ==========================================================
  // Write channel
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (aw_addr == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read channel
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= RESP_OKAY;
      if (s_axi_araddr_i == REG_CTRL)
        s_axi_rdata_o <= {28'h0, pulse_busy, ctrl};
      else if (s_axi_araddr_i == REG_STAT)
        s_axi_rdata_o <= {16'h0, 6'h0, rx_word, 3'h0, pulse_busy, rx_valid,
                          link.status_line, link.safety_output_b, link.safety_output_a};
      else
      begin
        s_axi_rdata_o <= 32'h0;
        s_axi_rresp_o <= RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ==========================================================
  // Control levels and restart pulse
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      ctrl <= 3'h0;
    else if (ctrl_wr)
      ctrl <= w_data[2:0];
  end

  // Busy pulse ignores, not stretches, a repeat
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      pulse_busy <= 1'b0;
      pulse_cnt <= 32'h0;
    end
    else if (ctrl_wr && w_data[3] && !pulse_busy)
    begin
      pulse_busy <= 1'b1;
      pulse_cnt <= 32'(RST_PULSE_CYC - 1);
    end
    else if (pulse_busy)
    begin
      if (pulse_cnt == 32'h0)
        pulse_busy <= 1'b0;
      else
        pulse_cnt <= pulse_cnt - 32'h1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      link.chain_input_a <= 1'b0;
      link.chain_input_b <= 1'b0;
      link.contactor_feedback_input <= 1'b0;
    end
    else
    begin
      link.chain_input_a <= ctrl[0];
      link.chain_input_b <= ctrl[1];
      // restart pulse inside the valid window
      link.contactor_feedback_input <= ctrl[2] || pulse_busy;
    end
  end

  // ==========================================================
  // Status line receiver
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      rx_state <= RX_IDLE;
      rcnt <= 32'h0;
      rleft <= 4'h0;
      rshift <= '0;
      rx_word <= '0;
      rx_valid <= 1'b0;
      line_prev <= 1'b1;
    end
    else
    begin
      line_prev <= link.status_line;
      if (stat_rd)
        rx_valid <= 1'b0;
      case (rx_state)
        RX_IDLE:
        begin
          if (line_prev && !link.status_line)
          begin
            rcnt <= 32'(BIT_CYC + BIT_CYC / 4 - 1);
            rleft <= 4'(CHAR_BITS);
            rx_state <= RX_BITS;
          end
        end
        RX_BITS:
        begin
          if (rcnt == 32'h0)
          begin
            // low first quarter reads as zero
            // high first quarter reads as one
            rshift <= {link.status_line, rshift[CHAR_BITS-1:1]};
            rleft <= rleft - 4'h1;
            rcnt <= 32'(BIT_CYC - 1);
            if (rleft == 4'h1)
            begin
              rx_word <= {link.status_line, rshift[CHAR_BITS-1:1]};
              rx_valid <= 1'b1;
              rx_state <= RX_WAIT;
            end
          end
          else
            rcnt <= rcnt - 32'h1;
        end
        RX_WAIT:
        begin
          // Last cell edges must not read as a start
          if (!link.status_line)
            rcnt <= 32'(BIT_CYC - 1);
          else if (rcnt == 32'h0)
            rx_state <= RX_IDLE;
          else
            rcnt <= rcnt - 32'h1;
        end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

endmodule

// *** tb/sss_checker.sv ***
// Link checks: status character and test pulses.
// Assumes serial variant, no fault, short counts.
`timescale 1ns/1ps
module sss_checker
#(
  parameter int BIT_CYC = 40,
  parameter int GAP_CYC = 200,
  parameter int SHIFT_CYC = 3000,
  parameter int PERIOD_CYC = 6000
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link wires
  input wire logic status_line,
  input wire logic safety_output_a,
  input wire logic safety_output_b,
  input wire logic chain_input_a,
  input wire logic chain_input_b,
  input wire logic contactor_feedback_input
);
  import sss_pkg::*;
  localparam int CENTRE1 = 2 * BIT_CYC + BIT_CYC / 2;
  int pos, hi_run, cnt;
  logic exp_one;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  // ==========================================
  // Position in character
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      pos <= 0;
    else if (pos == 0 && $fell(status_line))
      pos <= 1;
    else if (pos != 0)
      pos <= (pos == 3 * BIT_CYC) ? 0 : pos + 1;
  end
  // Chain bit as the sender sampled it
  always_ff @(posedge clock_i)
  begin
    if (pos == 0 && $fell(status_line))
      exp_one <= $past(chain_input_a, 2) & $past(chain_input_b, 2);
  end
  // Idle run, pulse period
  always_ff @(posedge clock_i)
  begin
    hi_run <= (reset_n_i && status_line) ? hi_run + 1 : 0;
    cnt <= (!reset_n_i || cnt == PERIOD_CYC - 1) ? 0 : cnt + 1;
  end
  // ==========================================
  // Properties
  sequence s_start;
    pos == 0 && $fell(status_line);
  endsequence
  property p_start_low;
    pos >= 1 && pos < BIT_CYC |-> !status_line;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start short");
  property p_gap;
    s_start |-> hi_run >= GAP_CYC - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("gap short");
  property p_centre;
    pos == BIT_CYC + BIT_CYC / 2 || pos == CENTRE1 |-> status_line != $past(status_line);
  endproperty
  a_centre: assert property (p_centre) else $error("no centre edge");
  property p_bit_one;
    s_start ##CENTRE1 1'b1 |-> status_line == !exp_one;
  endproperty
  a_bit_one: assert property (p_bit_one) else $error("chain bit wrong");
  property p_repeat;
    status_line |-> hi_run <= GAP_CYC + BIT_CYC;
  endproperty
  a_repeat: assert property (p_repeat) else $error("no repeat");
  property p_pulse_a;
    cnt >= 2 && cnt < PULSE_CYC |-> !safety_output_a;
  endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("pulse a missing");
  property p_pulse_b;
    cnt >= SHIFT_CYC + 2 && cnt < SHIFT_CYC + PULSE_CYC |-> !safety_output_b;
  endproperty
  a_pulse_b: assert property (p_pulse_b) else $error("pulse b missing");
  property p_pair;
    (cnt >= PULSE_CYC + 2 && cnt < SHIFT_CYC) || cnt >= SHIFT_CYC + PULSE_CYC + 2
      |-> safety_output_a == safety_output_b;
  endproperty
  a_pair: assert property (p_pair) else $error("outputs differ");
  property p_reset;
    !$past(reset_n_i) |-> status_line && !safety_output_a && !safety_output_b
      && !chain_input_a && !chain_input_b && !contactor_feedback_input;
  endproperty
  a_reset: assert property (p_reset) else $error("link not idle");
endmodule

// *** tb/tb.sv ***
// Bench: controller, linked sensor, teach-wired sensor.
// Assumes shortened counts.
`timescale 1ns/1ps
module tb;
  import sss_pkg::*;
  localparam int B = 40;
  localparam int G = 200;
  localparam int S = 3000, P = 6000, RMIN = 10, RMAX = 100, BL = 4, RP = 20;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic guard = 1'b0, guard2 = 1'b0, fb2 = 1'b0, red, prog = 1'b0, ser1 = 1'b1, ser2 = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf, fault2 = 4'h0, fault1 = 4'h0;
  logic [31:0] wdata = 32'h0, st, rdata;
  logic awready, wready, bvalid, arready, rvalid, on1, on2, te2;
  logic [1:0] bresp, rresp, led1, led2, rs, ch;
  sss_mode_e mode = SSS_AUTO;
  int n_fail = 0;
  int n_compared = 0;
  sss_link_if lnk();
  sss_link_if lnk2();
  // Teach wiring on the second sensor
  assign lnk2.chain_input_a = lnk2.safety_output_a;
  assign lnk2.chain_input_b = lnk2.status_line;
  assign lnk2.contactor_feedback_input = fb2;
  sss_device #(.BIT_CYC(B), .GAP_CYC(G), .SHIFT_CYC(S), .PERIOD_CYC(P), .RST_MIN_CYC(RMIN),
    .RST_MAX_CYC(RMAX), .BLINK_CYC(BL)) sss_device_inst (.clock_i, .reset_n_i, .link(lnk),
    .guard_closed_i(guard), .programming_i(prog), .serial_variant_i(ser1), .mode_i(mode),
    .fault_code_i(fault1), .led_o(led1), .outputs_on_o(on1), .teach_enable_o());
  sss_device #(.BIT_CYC(B), .GAP_CYC(G), .SHIFT_CYC(S), .PERIOD_CYC(P), .RST_MIN_CYC(RMIN),
    .RST_MAX_CYC(RMAX), .BLINK_CYC(BL)) sss_device_inst_b (.clock_i, .reset_n_i, .link(lnk2),
    .guard_closed_i(guard2), .programming_i(prog), .serial_variant_i(ser2), .mode_i(mode),
    .fault_code_i(fault2), .led_o(led2), .outputs_on_o(on2), .teach_enable_o(te2));
  sss_ctrl #(.BIT_CYC(B), .RST_PULSE_CYC(RP)) sss_ctrl_inst (.clock_i, .reset_n_i, .link(lnk),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready));
  sss_checker #(.BIT_CYC(B), .GAP_CYC(G), .SHIFT_CYC(S), .PERIOD_CYC(P)) sss_checker_inst
    (.clock_i, .reset_n_i, .status_line(lnk.status_line), .safety_output_a(lnk.safety_output_a),
    .safety_output_b(lnk.safety_output_b), .chain_input_a(lnk.chain_input_a),
    .chain_input_b(lnk.chain_input_b), .contactor_feedback_input(lnk.contactor_feedback_input));
  initial forever #20 clock_i = ~clock_i;
  // ==========================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rst(input sss_mode_e m);
    mode <= m;
    reset_n_i <= 1'b0;
    cyc(5);
    reset_n_i <= 1'b1;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clock_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Reading status clears the valid flag, so a stale one goes first
  task automatic char_wait();
    st = 32'h0;
    for (int k = 0; k < 300 && !st[3]; k++) axr(REG_STAT, st, rs);
  endtask
  // ==========================================
  // Scenarios
  initial
  begin
    int c;
    logic g;
    logic [3:0] fc;
    c = $urandom(21646);
    for (int m = 0; m < 5; m++)
    begin
      rst(sss_mode_e'(m));
      c = 0;
      g = 1'b0;
      repeat (8 * (m + 2) + 4)
      begin
        @(posedge clock_i);
        if (led1 === LED_YELLOW && !g) c++;
        g = (led1 === LED_YELLOW);
      end
      chk("boot blinks", m + 2, c);
    end
    rst(SSS_AUTO);
    for (int i = 0; i < 4; i++)
    begin
      g = (i == 0) ? 1'b1 : 1'($urandom);
      ch = (i == 0) ? 2'h3 : 2'($urandom);
      guard <= g;
      axw(REG_CTRL, {30'h0, ch}, rs);
      repeat (3) char_wait();
      chk("chain a", ch[0], lnk.chain_input_a);
      chk("char", {ch[0] & ch[1], g}, st[9:8]);
      chk("outputs on", g, on1);
      chk("led", g ? LED_GREEN : LED_RED, led1);
    end
    axw(4'hc, 32'h0, rs);
    chk("unmapped bresp", RESP_SLVERR, rs);
    guard <= 1'b1;
    rst(SSS_MANUAL);
    cyc(100);
    chk("led waiting", LED_YELLOW, led1);
    axw(REG_CTRL, 32'h4, rs);
    cyc(120);
    axw(REG_CTRL, 32'h0, rs);
    cyc(5);
    chk("long press", 0, on1);
    axw(REG_CTRL, 32'h8, rs);
    cyc(40);
    chk("restart", 1, on1);
    rst(SSS_AUTO_FB);
    cyc(100);
    chk("no feedback", 0, on1);
    axw(REG_CTRL, 32'h4, rs);
    cyc(5);
    chk("feedback", 1, on1);
    rst(SSS_AUTO);
    cyc(100);
    for (int i = 0; i < 4; i++)
    begin
      g = 1'($urandom);
      fb2 <= ~g;
      guard2 <= g;
      cyc(4);
      chk("plain status", g, lnk2.status_line);
      chk("teach", !g, te2);
    end
    guard2 <= 1'b0;
    cyc(4);
    fc = 4'($urandom_range(7, 1));
    fault2 <= fc;
    while (lnk2.status_line !== 1'b1) @(posedge clock_i);
    c = 1;
    g = 1'b1;
    red = 1'b0;
    repeat (fc * B)
    begin
      @(posedge clock_i);
      if (lnk2.status_line && !g) c++;
      g = lnk2.status_line;
      red |= (led2 === LED_RED);
    end
    chk("fault pulses", fc, c);
    chk("fault led", 1, red);
    for (int k = 0; k < G + B && lnk2.status_line !== 1'b1; k++) @(posedge clock_i);
    chk("fault repeat", 1, lnk2.status_line);
    conclude();
  end
  initial
  begin
    cyc(30000);
    n_fail++;
    conclude();
  end
endmodule
